//--- core/rtd_cal_cfg.svh
/*
 Constants for the per-channel offset/gain calibration block of a four-channel RTD input.
 Assumes a single 200 MHz clock and a byte-wide register port driven by the module bus logic.
*/
// Functional notes
// [RQ1] Correct conversions only while calibration enable set.
// [RQ2] Every offset or gain write saved to flash.
// [RQ3] Calibration enable clears on reset, never stored.
// [RQ4] Power-up restores all offsets and gains from flash.
// [RQ5] Software avoids routine writes; flash wears out.
// [RQ6] Software checks temperature mode, then sets enable.
// [RQ7] Software writes low-end error times 100 as offset.
// [RQ8] Then high-end error times 100 as gain.
// [RQ9] Magnitude bits 0 to 22, hundredths of degree.
// [RQ10] Top bit is sign, one means negative.
// [RQ11] Value bytes read/write the selected channel.
// [RQ12] Settings: mode, enable, rate, averaging, reserved top.
// [RQ13] Software writes values before enabling calibration.
// [RQ14] Module runs only after startup activation set.
// [RQ15] Startup copies settings area into information area.
// [RQ16] Mode selects hundredths degree or milliohm output.
// [RQ17] Linear correction: remove offset low, gain high.
`ifndef RTD_CAL_CFG_SVH
`define RTD_CAL_CFG_SVH
`define ADDR_CONV_SET 8'h02
`define ADDR_CHAN_SEL 8'h0F
`define ADDR_OFS_BASE 8'h14
`define ADDR_GAIN_BASE 8'h17
`define ADDR_STARTUP 8'h30
`define ADDR_INFO_CONV 8'h31
`define ADDR_STATUS 8'h32
`define BIT_MODE 0
`define BIT_CAL_EN 1
`define CONV_RESERVED_MASK 8'h3F
`define RATE_LSB 2
`define RATE_MSB 3
`define AVG_LSB 4
`define AVG_MSB 5
`define VALUE_BYTES 8'h03
`define NUM_SLOTS 8
`define LAST_SLOT 3'h7
`define GAIN_SLOT_BASE 4
`define STARTUP_ACTIVE_BIT 0
`define SIGN_BIT 23
`define CAL_LOW_POINT 24'sd0
`define CAL_SPAN 24'sd100000
`define NUM_CH 4
`define FLASH_WRITE_CYCLES 16'h0010
`define FLASH_READ_CYCLES 16'h0004
`endif

//--- core/rtd_cal_pkg.sv
/*
 Types shared by the calibration block and its flash port.
 Assumes the constants header is included by the design files.
*/
package rtd_cal_pkg;
	typedef enum logic [2:0] {
		FL_RESTORE,
		FL_RESTORE_WAIT,
		FL_IDLE,
		FL_SAVE,
		FL_SAVE_WAIT
	} flash_state_t;
	typedef logic [23:0] cal_word_t;
endpackage : rtd_cal_pkg

//--- core/rtd_cal_corrector.sv
/*
 Linear correction of one sign-magnitude conversion result.
 Assumes inputs stable from the same clock; one-cycle registered output.
*/
`timescale 1ns/10ps
`include "rtd_cal_cfg.svh"
module rtd_cal_corrector (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic calEnable,
	input wire logic [23:0] rawValue,
	input wire logic [23:0] offsetValue,
	input wire logic [23:0] gainValue,
	output logic [23:0] corrValue
);
	logic [23:0] corrValue_reg;
	logic [23:0] corrValue_next;
	logic signed [47:0] rawS;
	logic signed [47:0] ofsS;
	logic signed [47:0] gainS;
	logic signed [47:0] prod;
	logic signed [47:0] res;
	logic [22:0] mag;

	// Sign-magnitude to two's complement.
	function automatic logic signed [47:0] toSigned(input logic [23:0] v);
		logic signed [47:0] m;
		m = {25'h0, v[22:0]};
		return v[`SIGN_BIT] ? -m : m;
	endfunction : toSigned

	always_comb begin
		rawS = toSigned(rawValue);
		ofsS = toSigned(offsetValue);
		gainS = toSigned(gainValue);
		prod = 48'sh0;
		res = rawS;
		mag = 23'h0;
		if (calEnable) begin // RQ1
			// Span fixed so gain error maps out at the high point; range limited by divide.
			prod = (rawS - ofsS) * 48'(`CAL_SPAN); // RQ17
			res = prod / (48'(`CAL_SPAN) + gainS - ofsS); // RQ17
		end
		if (res < 0) begin
			mag = 23'(-res);
		end else begin
			mag = 23'(res);
		end
		corrValue_next = {res < 0, mag}; // RQ10
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			corrValue_reg <= 24'h000000;
		end else begin
			corrValue_reg <= corrValue_next;
		end
	end
	assign corrValue = corrValue_reg;

	AST_BYPASS: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
		!calEnable |=> corrValue == $past(rawValue[`SIGN_BIT] && rawValue[22:0] != 0 ?
			rawValue : {1'b0, rawValue[22:0]}))
		else $error("Uncorrected value altered while calibration off");
endmodule : rtd_cal_corrector

//--- core/rtd_cal_block.sv
/*
 Offset/gain calibration registers, flash save and restore, startup copy, and the
 per-channel correction path for a four-channel RTD input.
 Assumes a byte register port from the module bus logic and a simple flash word port.
*/
`timescale 1ns/10ps
`include "rtd_cal_cfg.svh"
module rtd_cal_block (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic rawValid,
	input wire logic [1:0] rawChannel,
	input wire logic [23:0] rawValue,
	output logic [23:0] corrValue,
	output logic [1:0] corrChannel,
	output logic corrValid,
	output logic moduleActive,
	output logic modeResistance,
	output logic [1:0] conversionRateField,
	output logic [1:0] averagingField,
	output logic flashWrite,
	output logic flashRead,
	output logic [2:0] flashAddr,
	output logic [23:0] flashWdata,
	input wire logic [23:0] flashRdata,
	input wire logic flashDone
);
	// Flash slots: 0..3 offsets, 4..7 gains.
	logic [23:0] offsetArr_reg [`NUM_CH];
	logic [23:0] offsetArr_next [`NUM_CH];
	logic [23:0] gainArr_reg [`NUM_CH];
	logic [23:0] gainArr_next [`NUM_CH];
	logic [7:0] convSet_reg;
	logic [7:0] convSet_next;
	logic [7:0] infoConv_reg;
	logic [7:0] infoConv_next;
	logic [1:0] chanSel_reg;
	logic [1:0] chanSel_next;
	logic active_reg;
	logic active_next;
	logic [7:0] pendSave_reg;
	logic [7:0] pendSave_next;
	rtd_cal_pkg::flash_state_t flState_reg;
	rtd_cal_pkg::flash_state_t flState_next;
	logic [2:0] flSlot_reg;
	logic [2:0] flSlot_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [1:0] corrChan_reg;
	logic [1:0] corrChan_next;
	logic corrValid_reg;
	logic corrValid_next;
	logic [7:0] wrOfsBits;
	logic [7:0] wrGainBits;
	logic [1:0] byteSel;
	logic restoring;

	assign restoring = flState_reg == rtd_cal_pkg::FL_RESTORE
		|| flState_reg == rtd_cal_pkg::FL_RESTORE_WAIT;

	// Register file next-state, including byte writes to the selected channel.
	always_comb begin
		convSet_next = convSet_reg;
		infoConv_next = infoConv_reg;
		chanSel_next = chanSel_reg;
		active_next = active_reg;
		offsetArr_next = offsetArr_reg;
		gainArr_next = gainArr_reg;
		wrOfsBits = 8'h00;
		wrGainBits = 8'h00;
		byteSel = 2'h0;
		if (regWrite && !restoring) begin
			if (regAddr == `ADDR_CONV_SET) begin
				convSet_next = regWdata & `CONV_RESERVED_MASK; // RQ12
			end
			if (regAddr == `ADDR_CHAN_SEL) begin
				chanSel_next = regWdata[1:0];
			end
			if (regAddr == `ADDR_STARTUP) begin
				active_next = regWdata[`STARTUP_ACTIVE_BIT]; // RQ14
				if (regWdata[`STARTUP_ACTIVE_BIT] && !active_reg) begin
					infoConv_next = convSet_reg; // RQ15
				end
			end
			if (regAddr >= `ADDR_OFS_BASE && regAddr < `ADDR_GAIN_BASE) begin
				byteSel = 2'(regAddr - `ADDR_OFS_BASE);
				offsetArr_next[chanSel_reg][byteSel*8 +: 8] = regWdata; // RQ11 RQ9 RQ10
				wrOfsBits[chanSel_reg] = 1'b1; // RQ2
			end
			if (regAddr >= `ADDR_GAIN_BASE && regAddr < 8'(`ADDR_GAIN_BASE + `VALUE_BYTES)) begin
				byteSel = 2'(regAddr - `ADDR_GAIN_BASE);
				gainArr_next[chanSel_reg][byteSel*8 +: 8] = regWdata; // RQ11 RQ9 RQ10
				wrGainBits[`GAIN_SLOT_BASE + 32'(chanSel_reg)] = 1'b1; // RQ2
			end
		end
		if (flState_reg == rtd_cal_pkg::FL_RESTORE_WAIT && flashDone) begin
			if (flSlot_reg[2]) begin
				gainArr_next[flSlot_reg[1:0]] = flashRdata; // RQ4
			end else begin
				offsetArr_next[flSlot_reg[1:0]] = flashRdata; // RQ4
			end
		end
	end

	// Flash sequencer: restore all slots after reset, then save dirty slots.
	always_comb begin
		flState_next = flState_reg;
		flSlot_next = flSlot_reg;
		pendSave_next = pendSave_reg | wrOfsBits | wrGainBits; // RQ2
		unique case (flState_reg)
			rtd_cal_pkg::FL_RESTORE: begin
				flState_next = rtd_cal_pkg::FL_RESTORE_WAIT;
			end
			rtd_cal_pkg::FL_RESTORE_WAIT: begin
				if (flashDone) begin
					flSlot_next = flSlot_reg + 3'h1;
					flState_next = (flSlot_reg == `LAST_SLOT) ? rtd_cal_pkg::FL_IDLE
						: rtd_cal_pkg::FL_RESTORE; // RQ4
				end
			end
			rtd_cal_pkg::FL_IDLE: begin
				for (int i = 0; i < `NUM_SLOTS; i++) begin
					if (pendSave_reg[i] && flState_next == rtd_cal_pkg::FL_IDLE) begin
						flSlot_next = 3'(i);
						flState_next = rtd_cal_pkg::FL_SAVE;
					end
				end
			end
			rtd_cal_pkg::FL_SAVE: begin
				flState_next = rtd_cal_pkg::FL_SAVE_WAIT;
			end
			rtd_cal_pkg::FL_SAVE_WAIT: begin
				if (flashDone) begin
					flState_next = rtd_cal_pkg::FL_IDLE;
				end
			end
		endcase
		// A new write in the same cycle keeps the slot pending so the later value is saved.
		if (flState_reg == rtd_cal_pkg::FL_SAVE) begin
			pendSave_next[flSlot_reg] = wrOfsBits[flSlot_reg] | wrGainBits[flSlot_reg];
		end
	end

	// Read data and correction sideband.
	always_comb begin
		rdata_next = 8'h00;
		if (regRead) begin
			if (regAddr == `ADDR_CONV_SET) begin
				rdata_next = convSet_reg;
			end else if (regAddr == `ADDR_CHAN_SEL) begin
				rdata_next = {6'h00, chanSel_reg};
			end else if (regAddr == `ADDR_STARTUP) begin
				rdata_next = {7'h00, active_reg};
			end else if (regAddr == `ADDR_INFO_CONV) begin
				rdata_next = infoConv_reg; // RQ15
			end else if (regAddr == `ADDR_STATUS) begin
				rdata_next = {6'h00, flState_reg != rtd_cal_pkg::FL_IDLE, restoring};
			end else if (regAddr >= `ADDR_OFS_BASE && regAddr < `ADDR_GAIN_BASE) begin
				rdata_next = offsetArr_reg[chanSel_reg][2'(regAddr - `ADDR_OFS_BASE)*8 +: 8];
			end else if (regAddr >= `ADDR_GAIN_BASE
				&& regAddr < 8'(`ADDR_GAIN_BASE + `VALUE_BYTES)) begin
				rdata_next = gainArr_reg[chanSel_reg][2'(regAddr - `ADDR_GAIN_BASE)*8 +: 8];
			end
		end
		corrValid_next = rawValid && active_reg && !restoring; // RQ14
		corrChan_next = rawChannel;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			convSet_reg <= 8'h00; // RQ3
			infoConv_reg <= 8'h00;
			chanSel_reg <= 2'h0;
			active_reg <= 1'b0;
			pendSave_reg <= 8'h00;
			flState_reg <= rtd_cal_pkg::FL_RESTORE;
			flSlot_reg <= 3'h0;
			rdata_reg <= 8'h00;
			corrChan_reg <= 2'h0;
			corrValid_reg <= 1'b0;
			for (int i = 0; i < `NUM_CH; i++) begin
				offsetArr_reg[i] <= 24'h000000;
				gainArr_reg[i] <= 24'h000000;
			end
		end else begin
			convSet_reg <= convSet_next;
			infoConv_reg <= infoConv_next;
			chanSel_reg <= chanSel_next;
			active_reg <= active_next;
			pendSave_reg <= pendSave_next;
			flState_reg <= flState_next;
			flSlot_reg <= flSlot_next;
			rdata_reg <= rdata_next;
			corrChan_reg <= corrChan_next;
			corrValid_reg <= corrValid_next;
			offsetArr_reg <= offsetArr_next;
			gainArr_reg <= gainArr_next;
		end
	end

	rtd_cal_corrector corrector (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.calEnable(convSet_reg[`BIT_CAL_EN]), // RQ1
		.rawValue(rawValue),
		.offsetValue(offsetArr_reg[rawChannel]),
		.gainValue(gainArr_reg[rawChannel]),
		.corrValue(corrValue)
	);

	assign regRdata = rdata_reg;
	assign corrChannel = corrChan_reg;
	assign corrValid = corrValid_reg;
	assign moduleActive = active_reg;
	assign modeResistance = convSet_reg[`BIT_MODE]; // RQ16
	assign conversionRateField = convSet_reg[`RATE_MSB:`RATE_LSB];
	assign averagingField = convSet_reg[`AVG_MSB:`AVG_LSB];
	assign flashWrite = flState_reg == rtd_cal_pkg::FL_SAVE;
	assign flashRead = flState_reg == rtd_cal_pkg::FL_RESTORE;
	assign flashAddr = flSlot_reg;
	assign flashWdata = flSlot_reg[2] ? gainArr_reg[flSlot_reg[1:0]]
		: offsetArr_reg[flSlot_reg[1:0]];

	AST_CAL_CLEAR: assert property (@(posedge core_clk) // RQ3
		!rst_n |=> convSet_reg == 8'h00)
		else $error("Settings not cleared by reset");

	AST_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ12
		(convSet_reg & ~`CONV_RESERVED_MASK) == 8'h00)
		else $error("Reserved settings bits set");

	AST_RESERVED_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ12
		regRead && regAddr == `ADDR_CONV_SET |=> (regRdata & ~`CONV_RESERVED_MASK) == 8'h00)
		else $error("Reserved settings bits read back set");

	AST_CAL_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
		regWrite && !restoring && regAddr == `ADDR_CONV_SET
		|=> convSet_reg[`BIT_CAL_EN] == $past(regWdata[`BIT_CAL_EN]))
		else $error("Calibration enable does not follow the settings write");

	// Writes are dropped while the store is read back, so a restore is never half overwritten.
	AST_RESTORE_LOCK: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
		regWrite && restoring |=> $stable(convSet_reg) && $stable(chanSel_reg))
		else $error("Register write taken during restore");

	AST_SAVE_PEND: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ2
		regWrite && !restoring && regAddr >= `ADDR_OFS_BASE && regAddr < `ADDR_GAIN_BASE
		|=> pendSave_reg[$past(chanSel_reg)])
		else $error("Offset write not queued for flash");

	AST_GAIN_PEND: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ2
		regWrite && !restoring && regAddr >= `ADDR_GAIN_BASE
		&& regAddr < 8'(`ADDR_GAIN_BASE + `VALUE_BYTES)
		|=> pendSave_reg[`GAIN_SLOT_BASE + 32'($past(chanSel_reg))])
		else $error("Gain write not queued for flash");

	AST_SAVE_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ2
		flashWrite |=> !flashWrite && !flashRead)
		else $error("Flash save strobe longer than one cycle");

	AST_OFS_STORE: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ11
		regWrite && !restoring && regAddr == `ADDR_OFS_BASE
		|=> offsetArr_reg[$past(chanSel_reg)][7:0] == $past(regWdata))
		else $error("Offset byte not stored for the selected channel");

	AST_RESTORE_FIRST: assert property (@(posedge core_clk) // RQ4
		!rst_n |=> flashRead && flashAddr == 3'h0)
		else $error("Restore not started after reset");

	AST_RESTORE_NEXT: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
		flState_reg == rtd_cal_pkg::FL_RESTORE_WAIT && flashDone && flSlot_reg != `LAST_SLOT
		|=> flashRead && flashAddr == 3'($past(flSlot_reg) + 3'h1))
		else $error("Restore skipped a slot");

	AST_RESTORE_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
		flState_reg == rtd_cal_pkg::FL_RESTORE_WAIT && flashDone
		|=> ($past(flSlot_reg[2]) ? gainArr_reg[$past(flSlot_reg[1:0])]
			: offsetArr_reg[$past(flSlot_reg[1:0])]) == $past(flashRdata))
		else $error("Restored word not loaded");

	AST_RESTORE_END: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
		flState_reg == rtd_cal_pkg::FL_RESTORE_WAIT && flashDone && flSlot_reg == `LAST_SLOT
		|=> !restoring)
		else $error("Restore did not finish after the last slot");

	AST_NO_OUT_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ14
		corrValid |-> $past(active_reg))
		else $error("Output while module stopped");

	AST_NO_OUT_RESTORE: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ14
		restoring |=> !corrValid)
		else $error("Output while restore still running");

	AST_OUT_ACTIVE: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ14
		rawValid && active_reg && !restoring |=> corrValid && corrChannel == $past(rawChannel))
		else $error("Conversion lost while module running");

	AST_INFO_COPY: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ15
		regWrite && !restoring && regAddr == `ADDR_STARTUP
		&& regWdata[`STARTUP_ACTIVE_BIT] && !active_reg
		|=> infoConv_reg == $past(convSet_reg))
		else $error("Information copy missing at startup");

	AST_SEL_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ11
		regRead && regAddr == `ADDR_OFS_BASE
		|=> regRdata == $past(offsetArr_reg[chanSel_reg][7:0]))
		else $error("Offset read from wrong channel");

	AST_MODE_OUT: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ16
		regWrite && !restoring && regAddr == `ADDR_CONV_SET
		|=> modeResistance == $past(regWdata[`BIT_MODE]))
		else $error("Mode output does not follow the settings write");
endmodule : rtd_cal_block

//--- dv/rtd_flash_model.sv
/*
 Behavioural flash word store facing the block's flash port.
 Assumes one strobe per operation and that the block waits for flashDone.
*/
`timescale 1ns/10ps
module rtd_flash_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic flashWrite,
	input wire logic flashRead,
	input wire logic [2:0] flashAddr,
	input wire logic [23:0] flashWdata,
	output logic [23:0] flashRdata,
	output logic flashDone
);
	logic [23:0] mem [8];
	logic [2:0] slot;
	logic isRead;
	logic slow;
	logic loaded = 1'b0;
	int waitCnt;
	// Read data is only good with done; between answers the bus churns so a late sample fails.
	// Requests seen during reset are dropped; contents survive reset as they survive power loss.
	always @(posedge core_clk) begin
		flashDone <= 1'b0;
		flashRdata <= ~flashRdata;
		if (!rst_n) begin
			flashRdata <= 24'h000000;
			waitCnt <= 0;
			slow <= 1'b0;
			if (!loaded) begin
				for (int i = 0; i < 8; i++) begin
					mem[i] <= {i[0], 23'(i * 37 + 3)};
				end
				loaded <= 1'b1;
			end
		end else if (waitCnt != 0) begin
			waitCnt <= waitCnt - 1;
			if (waitCnt == 1) begin
				flashDone <= 1'b1;
				if (isRead) begin
					flashRdata <= mem[slot];
				end
			end
		end else if (flashRead || flashWrite) begin
			slot <= flashAddr;
			isRead <= flashRead;
			if (flashWrite) begin
				mem[flashAddr] <= flashWdata;
			end
			// Prompt and slow answers alternate.
			waitCnt <= slow ? 7 : 1;
			slow <= ~slow;
		end
	end
endmodule : rtd_flash_model

//--- dv/rtd_cal_block_tb.sv
/*
 Self-checking bench for the calibration block with a flash model.
 Assumes the block's header constants and its hand-over timing.
*/
`timescale 1ns/10ps
`include "rtd_cal_cfg.svh"
module rtd_cal_block_tb;
	logic core_clk, rst_n, regWrite, regRead, rawValid, flashDone, corrValid;
	logic moduleActive, modeResistance, flashWrite, flashRead, seen, calOn;
	logic [7:0] regAddr, regWdata, regRdata, d;
	logic [1:0] rawChannel, corrChannel, conversionRateField, averagingField, ch, vch;
	logic [23:0] rawValue, corrValue, flashWdata, flashRdata, raw, val;
	logic [23:0] ofs [4];
	logic [23:0] gn [4];
	logic [2:0] flashAddr;
	int fails = 0;
	int numChecks = 0;
	int seed = 32'hB63B6D31;
	rtd_cal_block uut (.core_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
		.rawValid, .rawChannel, .rawValue, .corrValue, .corrChannel, .corrValid, .moduleActive,
		.modeResistance, .conversionRateField, .averagingField, .flashWrite, .flashRead,
		.flashAddr, .flashWdata, .flashRdata, .flashDone);
	rtd_flash_model flash (.core_clk, .rst_n, .flashWrite, .flashRead, .flashAddr, .flashWdata,
		.flashRdata, .flashDone);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	function automatic longint sm(input logic [23:0] v);
		return v[23] ? -longint'(v[22:0]) : longint'(v[22:0]);
	endfunction : sm
	function automatic logic [23:0] expCorr(input logic en, input logic [23:0] r, o, g);
		longint q;
		if (!en) begin
			return r;
		end
		q = (sm(r) - sm(o)) * `CAL_SPAN / (`CAL_SPAN + sm(g) - sm(o));
		return {q < 0, 23'(q < 0 ? -q : q)};
	endfunction : expCorr
	function automatic logic [23:0] randSm(input int lim);
		int r;
		int m;
		r = $random(seed);
		m = (r & 32'h7FFFFFFF) % lim;
		return {r[31] && m != 0, 23'(m)};
	endfunction : randSm
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = v;
		@(negedge core_clk);
		regWrite = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge core_clk);
		d = regRdata;
		regRead = 1'b0;
	endtask : rd
	task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(name, {16'h0000, exp}, {16'h0000, d});
	endtask : rdChk
	task automatic rd3Chk(input string name, input logic [7:0] a, input logic [23:0] exp);
		for (int i = 0; i < 3; i++) begin
			rdChk(name, a + 8'(i), exp[8 * i +: 8]);
		end
	endtask : rd3Chk
	task automatic wr3(input logic [7:0] a, input logic [23:0] v);
		for (int i = 0; i < 3; i++) begin
			wr(a + 8'(i), v[8 * i +: 8]);
		end
	endtask : wr3
	task automatic waitIdle();
		d = 8'hFF;
		for (int k = 0; k < 400 && d[1:0] != 2'b00; k++) begin
			rd(`ADDR_STATUS);
		end
		chk("status", 24'h000000, {22'h0, d[1:0]});
	endtask : waitIdle
	task automatic conv(input logic [1:0] c, input logic [23:0] r);
		@(negedge core_clk);
		rawValid = 1'b1;
		rawChannel = c;
		rawValue = r;
		@(negedge core_clk);
		rawValid = 1'b0;
		seen = 1'b0;
		for (int k = 0; k < 3 && !seen; k++) begin
			if (corrValid === 1'b1) begin
				seen = 1'b1;
				val = corrValue;
				vch = corrChannel;
			end else begin
				@(negedge core_clk);
			end
		end
	endtask : conv
	task automatic closeOut();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : closeOut
	initial begin
		#200us;
		fails++;
		closeOut();
	end
	initial begin
		rst_n = 1'b0;
		{regWrite, regRead, rawValid, regAddr, regWdata, rawChannel, rawValue} = '0;
		repeat (8) @(negedge core_clk);
		rst_n = 1'b1;
		waitIdle();
		rdChk("settings", `ADDR_CONV_SET, 8'h00);
		rdChk("unmapped", 8'hFE, 8'h00);
		for (int c = 0; c < 4; c++) begin
			ofs[c] = {c[0], 23'(c * 37 + 3)};
			gn[c] = {c[0], 23'(c * 37 + 151)};
			wr(`ADDR_CHAN_SEL, 8'(c));
			rd3Chk("offset", `ADDR_OFS_BASE, ofs[c]);
			rd3Chk("gain", `ADDR_GAIN_BASE, gn[c]);
		end
		wr(`ADDR_CONV_SET, 8'hFF);
		rdChk("settings", `ADDR_CONV_SET, 8'h3F);
		chk("fields", 24'h00001F, {19'h0, modeResistance, conversionRateField, averagingField});
		wr(`ADDR_CONV_SET, 8'h0C);
		conv(2'h1, 24'h001234);
		chk("idle output", 24'h000000, {23'h0, seen});
		wr(`ADDR_STARTUP, 8'h01);
		chk("active", 24'h000001, {23'h0, moduleActive});
		rdChk("info copy", `ADDR_INFO_CONV, 8'h0C);
		// Each value is written once only; the store wears with every write.
		for (int c = 0; c < 4; c++) begin
			ofs[c] = randSm(32'h00000BB8);
			gn[c] = randSm(32'h00000BB8);
			wr(`ADDR_CHAN_SEL, 8'(c));
			wr3(`ADDR_OFS_BASE, ofs[c]);
			wr3(`ADDR_GAIN_BASE, gn[c]);
		end
		rd3Chk("offset", `ADDR_OFS_BASE, ofs[3]);
		waitIdle();
		for (int c = 0; c < 4; c++) begin
			chk("saved offset", ofs[c], flash.mem[c]);
			chk("saved gain", gn[c], flash.mem[c + 4]);
		end
		for (int i = 0; i < 40; i++) begin
			calOn = i >= 16;
			if (i == 16) begin
				rdChk("mode", `ADDR_CONV_SET, 8'h0C);
				wr(`ADDR_CONV_SET, 8'h0E);
			end
			raw = randSm(32'h00014C08);
			ch = 2'($random(seed));
			conv(ch, raw);
			chk("valid", 24'h000001, {23'h0, seen});
			chk("corrected", expCorr(calOn, raw, ofs[ch], gn[ch]), val);
			chk("channel", {22'h0, ch}, {22'h0, vch});
		end
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		wr(`ADDR_CONV_SET, 8'h02);
		waitIdle();
		rdChk("settings", `ADDR_CONV_SET, 8'h00);
		chk("active", 24'h000000, {23'h0, moduleActive});
		wr(`ADDR_CHAN_SEL, 8'h02);
		rd3Chk("gain", `ADDR_GAIN_BASE, gn[2]);
		closeOut();
	end
endmodule : rtd_cal_block_tb
